// ### hw/pbof_top.sv
// payload bitstream formatter: per-port serialiser and apb register bank
// Operation
// - parity enabled gives even parity for sense 0, odd for sense 1.
// - port 1 frame strobe with first control bit, or one clock earlier.
// - port 1 channel strobe with first channel bit, or one clock earlier.
// - port 1 byte strobe with first byte bit, or one clock earlier.
// - shared pin carries frame sync for select 0, error flag for 1.
// - port 0 channel strobe one clock early when set, else aligned.
// - port 0 byte strobe one clock early when set, else aligned.
// - alarm bit per port set on a transmission error.
// - reading the alarm register clears both alarm bits.
// - serial clock is master over 2*(divisor+1), invertible, gated or free.
// - frame flag zero, first control byte, or first byte of each channel.
// - flag and parity appended after the byte; msb or lsb first.
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps

module pbof_port
   import pbof_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire pbof_cfg_s cfg_i,
   input wire pbof_byte_s byte_i,
   input wire logic byte_valid_i,
   output logic byte_ready_o,
   output logic sclk_o,
   output logic sdata_o,
   output pbof_sync_s sync_o
);
   logic [DIV_W-1:0] cnt;
   logic phase;
   logic tick;
   logic run;
   pbof_state_e st;
   logic [WORD_W-1:0] shreg;
   logic [LEFT_W-1:0] left;
   logic [WORD_W-1:0] word;
   logic [LEFT_W-1:0] word_len;
   logic [BYTE_W-1:0] ordered;
   logic flag;
   logic par;
   pbof_sync_s early;
   pbof_sync_s aligned;
   // half-period counter; a bit lasts (div+1)*2 master cycles
   assign tick = phase && (cnt == cfg_i.div);
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         cnt <= '0;
         phase <= 1'b0;
      end
      else if (cnt == cfg_i.div)
      begin
         cnt <= '0;
         phase <= ~phase;
      end
      else
         cnt <= cnt + DIV_W'(1);
   end
   // clock stops low (or high if inverted) between words unless free running
   assign run = cfg_i.free || (st != ST_IDLE);
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         sclk_o <= 1'b0;
      else
         sclk_o <= (((cnt == cfg_i.div) ? ~phase : phase) & run) ^ cfg_i.inv;
   end
   // word assembly: data in shift order, then flag, then parity
   always_comb
   begin
      ordered = byte_i.data;
      if (!cfg_i.lsb_first)
         for (int i = 0; i < BYTE_W; i++)
            ordered[i] = byte_i.data[BYTE_W-1-i];
      case (cfg_i.fmode)
         FF_ZERO: flag = 1'b0;
         FF_CTL: flag = byte_i.ctl_first;
         default: flag = byte_i.prc_first;
      endcase
      par = (^byte_i.data) ^ cfg_i.odd;
      word = cfg_i.flag_en ? {par, flag, ordered} : {1'b0, par, ordered};
      word_len = LEFT_BYTE + LEFT_W'(cfg_i.flag_en) + LEFT_W'(cfg_i.par_en);
   end
   // strobe sets for the byte on offer: the early ones go a bit ahead
   always_comb
   begin
      early.frame = byte_i.ctl_first & cfg_i.frm_early;
      early.chan = byte_i.prc_first & cfg_i.chn_early;
      early.byt = cfg_i.byt_early;
      aligned.frame = byte_i.ctl_first & ~cfg_i.frm_early;
      aligned.chan = byte_i.prc_first & ~cfg_i.chn_early;
      aligned.byt = ~cfg_i.byt_early;
   end
   // the byte is taken at the bit boundary where its first bit goes out
   assign byte_ready_o = tick && ((st == ST_LEAD) || ((st == ST_SHIFT) && (left == LEFT_LAST)));
   // serialiser; from idle one lead slot is spent so early strobes have room
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         st <= ST_IDLE;
         shreg <= '0;
         left <= '0;
         sdata_o <= 1'b0;
         sync_o <= '0;
      end
      else if (tick)
      begin
         case (st)
            ST_IDLE:
            begin
               if (byte_valid_i)
               begin
                  st <= ST_LEAD;
                  sync_o <= early;
               end
            end
            ST_LEAD:
            begin
               if (byte_valid_i)
               begin
                  st <= ST_SHIFT;
                  shreg <= word;
                  sdata_o <= word[0];
                  left <= word_len;
                  sync_o <= aligned;
               end
               else
               begin
                  st <= ST_IDLE;
                  sync_o <= '0;
               end
            end
            ST_SHIFT:
            begin
               if (left > LEFT_LAST)
               begin
                  shreg <= shreg >> 1;
                  sdata_o <= shreg[1];
                  left <= left - LEFT_LAST;
                  // next byte already waiting: its early strobes ride on our last bit
                  if ((left == LEFT_LAST + LEFT_LAST) && byte_valid_i)
                     sync_o <= early;
                  else
                     sync_o <= '0;
               end
               else if (byte_valid_i)
               begin
                  shreg <= word;
                  sdata_o <= word[0];
                  left <= word_len;
                  sync_o <= aligned;
               end
               else
               begin
                  st <= ST_IDLE;
                  sdata_o <= 1'b0;
                  sync_o <= '0;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
   // parity sits right above the data, or above the flag when that is on
   chk_parity_sense: assert property (@(posedge mclk_i) disable iff (srst_i)
      (byte_ready_o && byte_valid_i && cfg_i.par_en)
      |=> (((^shreg[BYTE_W-1:0]) ^ ($past(cfg_i.flag_en) ? shreg[WORD_W-1] : shreg[BYTE_W]))
         == $past(cfg_i.odd)))
      else $error("parity bit does not match sense");
   chk_byte_aligned: assert property (@(posedge mclk_i) disable iff (srst_i)
      (byte_ready_o && byte_valid_i) |=> (sync_o.byt == !$past(cfg_i.byt_early)))
      else $error("byte strobe wrong at first bit");
   chk_frame_early: assert property (@(posedge mclk_i) disable iff (srst_i)
      (tick && st == ST_IDLE && byte_valid_i && byte_i.ctl_first && cfg_i.frm_early)
      |=> sync_o.frame)
      else $error("early frame strobe missing");
   chk_chan_aligned: assert property (@(posedge mclk_i) disable iff (srst_i)
      (byte_ready_o && byte_valid_i && byte_i.prc_first && !cfg_i.chn_early)
      |=> sync_o.chan)
      else $error("aligned channel strobe missing");
   // at divisor 0 a bit is exactly two cycles, so only the next cycle is free of ticks
   chk_div_bound: assert property (@(posedge mclk_i) disable iff (srst_i)
      ($stable(cfg_i.div) && tick) |=> !tick)
      else $error("serial bit shorter than two master cycles");
   chk_word_len: assert property (@(posedge mclk_i) disable iff (srst_i)
      (st == ST_SHIFT) |-> (left <= LEFT_W'(WORD_W)))
      else $error("word longer than data plus flag plus parity");
endmodule

module pbof_top
   import pbof_pkg::*;
#(
   parameter int PORTS = 2
)
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire pbof_byte_s port0_byte_i,
   input wire logic port0_byte_valid_i,
   output logic port0_byte_ready_o,
   input wire logic port0_tx_error_i,
   input wire pbof_byte_s port1_byte_i,
   input wire logic port1_byte_valid_i,
   output logic port1_byte_ready_o,
   input wire logic port1_tx_error_i,
   output logic port0_serial_clock_o,
   output logic port0_serial_data_o,
   output logic port0_channel_sync_out_o,
   output logic port0_byte_sync_out_o,
   output logic port0_sync_or_error_pin_o,
   output logic port1_serial_clock_o,
   output logic port1_serial_data_o,
   output logic port1_frame_sync_out_o,
   output logic port1_channel_sync_out_o,
   output logic port1_byte_sync_out_o,
   output logic port1_sync_or_error_pin_o
);
   logic [6:0] clk_cfg [PORTS];
   logic [5:0] dat_cfg [PORTS];
   logic [7:0] sync_strobe_config;
   logic [1:0] transmission_alarm;
   logic [ADR_W-ADR_LSB-1:0] idx;
   logic acc;
   logic hit;
   logic alarm_rd;
   pbof_cfg_s cfg [PORTS];
   pbof_byte_s byte_in [PORTS];
   logic valid_in [PORTS];
   logic ready_out [PORTS];
   logic sclk [PORTS];
   logic sdata [PORTS];
   pbof_sync_s sync [PORTS];
   logic [1:0] tx_err;
   logic [1:0] pin;
   // zero-wait slave: every access completes in its first access cycle
   assign idx = paddr_i[ADR_W-1:ADR_LSB];
   assign acc = psel_i && penable_i;
   assign hit = (idx == IDX_CLK0) || (idx == IDX_CLK1) || (idx == IDX_DAT0) ||
                (idx == IDX_DAT1) || (idx == IDX_SYNC) || (idx == IDX_ALARM);
   assign pready_o = 1'b1;
   assign pslverr_o = acc && !hit;
   assign alarm_rd = acc && !pwrite_i && (idx == IDX_ALARM);
   // read mux; unused upper bits read as zero
   always_comb
   begin
      case (idx)
         IDX_CLK0: prdata_o = DATA_W'(clk_cfg[0]);
         IDX_CLK1: prdata_o = DATA_W'(clk_cfg[1]);
         IDX_DAT0: prdata_o = DATA_W'(dat_cfg[0]);
         IDX_DAT1: prdata_o = DATA_W'(dat_cfg[1]);
         IDX_SYNC: prdata_o = DATA_W'(sync_strobe_config);
         IDX_ALARM: prdata_o = DATA_W'(transmission_alarm);
         default: prdata_o = '0;
      endcase
   end
   // configuration registers
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         clk_cfg[0] <= RST_CLK;
         clk_cfg[1] <= RST_CLK;
         dat_cfg[0] <= RST_DAT;
         dat_cfg[1] <= RST_DAT;
         sync_strobe_config <= RST_SYNC;
      end
      else if (acc && pwrite_i)
      begin
         case (idx)
            IDX_CLK0: clk_cfg[0] <= pwdata_i[6:0];
            IDX_CLK1: clk_cfg[1] <= pwdata_i[6:0];
            IDX_DAT0: dat_cfg[0] <= pwdata_i[5:0];
            IDX_DAT1: dat_cfg[1] <= pwdata_i[5:0];
            IDX_SYNC: sync_strobe_config <= pwdata_i[7:0];
            default: ;
         endcase
      end
   end
   // alarm flags: a new error in the clearing read cycle survives the clear
   assign tx_err = {port1_tx_error_i, port0_tx_error_i};
   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
         transmission_alarm <= RST_ALARM;
      else
         transmission_alarm <= tx_err | (transmission_alarm & {2{~alarm_rd}});
   end
   assign byte_in[0] = port0_byte_i;
   assign byte_in[1] = port1_byte_i;
   assign valid_in[0] = port0_byte_valid_i;
   assign valid_in[1] = port1_byte_valid_i;
   // one serialiser per port, each with its own slice of the sync register
   for (genvar p = 0; p < PORTS; p++)
   begin : g_port
      always_comb
      begin
         cfg[p].div = clk_cfg[p][DIV_LSB +: DIV_W];
         cfg[p].inv = clk_cfg[p][INV_BIT];
         cfg[p].free = clk_cfg[p][FREE_BIT];
         cfg[p].fmode = dat_cfg[p][FMODE_LSB +: 2];
         cfg[p].flag_en = dat_cfg[p][FLAG_BIT];
         cfg[p].odd = dat_cfg[p][ODD_BIT];
         cfg[p].par_en = dat_cfg[p][PAR_BIT];
         cfg[p].lsb_first = dat_cfg[p][LSBF_BIT];
         cfg[p].frm_early = sync_strobe_config[p*SYNC_STRIDE+FRM_OFS];
         cfg[p].chn_early = sync_strobe_config[p*SYNC_STRIDE+CHN_OFS];
         cfg[p].byt_early = sync_strobe_config[p*SYNC_STRIDE+BYT_OFS];
      end
      pbof_port u_port (
         .mclk_i(mclk_i),
         .srst_i(srst_i),
         .cfg_i(cfg[p]),
         .byte_i(byte_in[p]),
         .byte_valid_i(valid_in[p]),
         .byte_ready_o(ready_out[p]),
         .sclk_o(sclk[p]),
         .sdata_o(sdata[p]),
         .sync_o(sync[p])
      );
      // shared pin: frame strobe or the port's alarm flag
      assign pin[p] = sync_strobe_config[p*SYNC_STRIDE+SEL_OFS] ?
                      transmission_alarm[p] : sync[p].frame;
   end
   assign port0_byte_ready_o = ready_out[0];
   assign port1_byte_ready_o = ready_out[1];
   assign port0_serial_clock_o = sclk[0];
   assign port1_serial_clock_o = sclk[1];
   assign port0_serial_data_o = sdata[0];
   assign port1_serial_data_o = sdata[1];
   assign port1_frame_sync_out_o = sync[1].frame;
   assign port0_channel_sync_out_o = sync[0].chan;
   assign port1_channel_sync_out_o = sync[1].chan;
   assign port0_byte_sync_out_o = sync[0].byt;
   assign port1_byte_sync_out_o = sync[1].byt;
   assign port0_sync_or_error_pin_o = pin[0];
   assign port1_sync_or_error_pin_o = pin[1];
   chk_pin_select: assert property (@(posedge mclk_i) disable iff (srst_i)
      sync_strobe_config[SEL_OFS+SYNC_STRIDE] |->
      (port1_sync_or_error_pin_o == transmission_alarm[1]))
      else $error("port 1 pin not showing the error flag");
   chk_alarm_set: assert property (@(posedge mclk_i) disable iff (srst_i)
      port0_tx_error_i |=> transmission_alarm[0])
      else $error("alarm not set after error");
   chk_alarm_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
      (alarm_rd && tx_err == 2'h0) |=> (transmission_alarm == 2'h0))
      else $error("alarm not cleared by read");
endmodule

// ### pkg/pbof_pkg.sv
// package of constants, types and register map for the payload bitstream formatter
package pbof_pkg;
   // register indices; byte address on the bus is four times the index
   localparam logic [11:0] IDX_CLK0 = 12'h500;
   localparam logic [11:0] IDX_CLK1 = 12'h501;
   localparam logic [11:0] IDX_DAT0 = 12'h502;
   localparam logic [11:0] IDX_DAT1 = 12'h503;
   localparam logic [11:0] IDX_SYNC = 12'h504;
   localparam logic [11:0] IDX_ALARM = 12'h506;
   localparam int ADR_W = 16;
   localparam int ADR_LSB = 2;
   localparam int DATA_W = 32;
   // reset values
   localparam logic [6:0] RST_CLK = 7'h00;
   localparam logic [5:0] RST_DAT = 6'h00;
   localparam logic [7:0] RST_SYNC = 8'h77;
   localparam logic [1:0] RST_ALARM = 2'h0;
   // clock register fields
   localparam int DIV_W = 5;
   localparam int DIV_LSB = 2;
   localparam int INV_BIT = 1;
   localparam int FREE_BIT = 0;
   // data register fields
   localparam int FMODE_LSB = 4;
   localparam int FLAG_BIT = 3;
   localparam int ODD_BIT = 2;
   localparam int PAR_BIT = 1;
   localparam int LSBF_BIT = 0;
   // sync register fields, port n sits at n*SYNC_STRIDE
   localparam int SYNC_STRIDE = 4;
   localparam int SEL_OFS = 3;
   localparam int FRM_OFS = 2;
   localparam int CHN_OFS = 1;
   localparam int BYT_OFS = 0;
   // serial word layout
   localparam int BYTE_W = 8;
   localparam int WORD_W = 10;
   localparam int LEFT_W = 4;
   localparam logic [LEFT_W-1:0] LEFT_LAST = 4'h1;
   localparam logic [LEFT_W-1:0] LEFT_BYTE = 4'h8;

   typedef enum logic [1:0] {
      FF_ZERO = 2'b00,
      FF_CTL = 2'b01
   } pbof_fmode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_SHIFT = 2'b10
   } pbof_state_e;

   typedef struct packed {
      logic [DIV_W-1:0] div;
      logic inv;
      logic free;
      logic [1:0] fmode;
      logic flag_en;
      logic odd;
      logic par_en;
      logic lsb_first;
      logic frm_early;
      logic chn_early;
      logic byt_early;
   } pbof_cfg_s;

   typedef struct packed {
      logic [BYTE_W-1:0] data;
      logic prc_first;
      logic ctl_first;
   } pbof_byte_s;

   typedef struct packed {
      logic frame;
      logic chan;
      logic byt;
   } pbof_sync_s;
endpackage

// ### tb/pbof_dec.sv
// decoder-side model: samples the serial stream on the active clock edge
`timescale 1ns/100ps
module pbof_dec
   import pbof_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic inv_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire pbof_sync_s sync_i
);
   logic sclk_d;
   int gap;
   int slot_q[$];
   int gap_q[$];
   // one slot per active edge; data and strobes are settled there
   always @(posedge mclk_i)
   begin
      sclk_d <= sclk_i ^ inv_i;
      gap <= gap + 1;
      if (srst_i)
         gap <= 0;
      else if ((sclk_i ^ inv_i) && !sclk_d)
      begin
         slot_q.push_back({sync_i, sdata_i});
         gap_q.push_back(gap);
         gap <= 1;
      end
   end
endmodule

// ### tb/tb_top.sv
// testbench: register bank and serial stream against a reference model
`timescale 1ns/100ps
module tb_top
   import pbof_pkg::*;
;
   logic mclk_i = 0;
   logic srst_i = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rdy0, rdy1;
   pbof_byte_s b0 = '0;
   pbof_byte_s b1 = '0;
   logic v0 = 0;
   logic v1 = 0;
   logic [1:0] ev = 2'h0;
   logic inv0 = 0;
   logic inv1 = 0;
   logic sc0, sd0, cs0, bs0, pin0, sc1, sd1, fs1, cs1, bs1, pin1;
   int failures = 0;
   int check_count = 0;
   int unsigned rs = 71104;
   int dv, inv, fm, fe, od, pe, lb, fr, ch, by;
   logic [9:0] bq[$];
   int ex[$];

   // master clock, 100 MHz
   always #5 mclk_i = ~mclk_i;

   pbof_top u_pbof_top (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .port0_byte_i(b0), .port0_byte_valid_i(v0), .port0_byte_ready_o(rdy0),
      .port0_tx_error_i(ev[0]), .port1_byte_i(b1), .port1_byte_valid_i(v1),
      .port1_byte_ready_o(rdy1), .port1_tx_error_i(ev[1]),
      .port0_serial_clock_o(sc0), .port0_serial_data_o(sd0),
      .port0_channel_sync_out_o(cs0), .port0_byte_sync_out_o(bs0),
      .port0_sync_or_error_pin_o(pin0), .port1_serial_clock_o(sc1),
      .port1_serial_data_o(sd1), .port1_frame_sync_out_o(fs1),
      .port1_channel_sync_out_o(cs1), .port1_byte_sync_out_o(bs1),
      .port1_sync_or_error_pin_o(pin1));
   // port 0 frame strobe only reaches the shared pin
   pbof_dec u_dec0 (.mclk_i(mclk_i), .srst_i(srst_i), .inv_i(inv0), .sclk_i(sc0),
      .sdata_i(sd0), .sync_i({pin0, cs0, bs0}));
   pbof_dec u_dec1 (.mclk_i(mclk_i), .srst_i(srst_i), .inv_i(inv1), .sclk_i(sc1),
      .sdata_i(sd1), .sync_i({fs1, cs1, bs1}));

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic int unsigned xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction

   function automatic logic [15:0] adr(input logic [11:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic give_up();
      failures++;
      $display("[FAIL] %0t wait limit reached", $time);
      end_sim();
   endtask

   // setup then access; data is settled well before the taking edge
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      logic rdy;
      @(posedge mclk_i);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1;
      for (n = 0; n < 20; n++)
      begin
         @(negedge mclk_i);
         rd = prdata;
         er = pslverr;
         rdy = pready;
         @(posedge mclk_i);
         if (rdy === 1'b1)
            break;
      end
      if (n == 20)
         give_up();
      psel <= 0;
      penable <= 0;
   endtask

   // valid stays high across bytes so words run back to back
   task automatic send(input int p);
      int n;
      logic rd;
      foreach (bq[k])
      begin
         if (p == 1)
            b1 <= bq[k];
         else
            b0 <= bq[k];
         v0 <= (p == 0);
         v1 <= (p == 1);
         for (n = 0; n < 500; n++)
         begin
            @(negedge mclk_i);
            rd = p ? rdy1 : rdy0;
            @(posedge mclk_i);
            if (rd === 1'b1)
               break;
         end
         if (n == 500)
            give_up();
      end
      v0 <= 0;
      v1 <= 0;
   endtask

   // reference slots {frame, chan, byte, data}; slot 0 is the lead slot
   task automatic build();
      int s, i;
      logic [7:0] d;
      ex.delete();
      ex.push_back(0);
      foreach (bq[k])
      begin
         d = bq[k][9:2];
         s = ex.size();
         for (i = 0; i < 8; i++)
            ex.push_back(lb ? d[i] : d[7-i]);
         if (fe)
            ex.push_back(fm == 0 ? 0 : (fm == 1 ? bq[k][0] : bq[k][1]));
         if (pe)
            ex.push_back(^d ^ od);
         ex[s - by] |= 2;
         if (bq[k][1])
            ex[s - ch] |= 4;
         if (bq[k][0])
            ex[s - fr] |= 8;
      end
   endtask

   task automatic run_case(input int p);
      int n, q[$], g[$];
      logic [31:0] r;
      logic er;
      r = xs();
      dv = r[1:0];
      inv = r[2];
      fm = r[4:3];
      fe = r[5] | (fm != 0);
      od = r[6];
      pe = r[7];
      lb = r[8];
      fr = r[9];
      ch = r[10];
      by = r[11];
      apb(1, adr(IDX_CLK0 + 12'(p)), 32'(dv * 4 + inv * 2), r, er);
      apb(1, adr(IDX_DAT0 + 12'(p)), 32'(fm * 16 + fe * 8 + od * 4 + pe * 2 + lb), r, er);
      apb(1, adr(IDX_SYNC), 32'((fr * 4 + ch * 2 + by) << (p * 4)), r, er);
      apb(0, adr(IDX_DAT0 + 12'(p)), 32'h0, r, er);
      check(r, 32'(fm * 16 + fe * 8 + od * 4 + pe * 2 + lb));
      inv0 <= (p == 0) & inv[0];
      inv1 <= (p == 1) & inv[0];
      bq.delete();
      for (n = 0; n < 3; n++)
         bq.push_back(10'(xs()));
      build();
      repeat (10) @(posedge mclk_i);
      u_dec0.slot_q.delete();
      u_dec1.slot_q.delete();
      u_dec0.gap_q.delete();
      u_dec1.gap_q.delete();
      send(p);
      for (n = 0; n < 2000; n++)
      begin
         @(posedge mclk_i);
         if ((p ? u_dec1.slot_q.size() : u_dec0.slot_q.size()) >= ex.size())
            break;
      end
      if (n == 2000)
         give_up();
      repeat (8 * (dv + 1) + 4) @(posedge mclk_i);
      // queues are copied by plain assignment; a conditional on queues is not portable
      if (p == 1)
      begin
         q = u_dec1.slot_q;
         g = u_dec1.gap_q;
      end
      else
      begin
         q = u_dec0.slot_q;
         g = u_dec0.gap_q;
      end
      check(q.size(), ex.size());
      foreach (ex[i])
         check(q[i], ex[i]);
      for (n = 1; n < g.size(); n++)
         check(g[n], 2 * (dv + 1));
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial
   begin
      int i, n;
      logic [31:0] r;
      logic er, pv;
      repeat (20) @(posedge mclk_i);
      srst_i <= 0;
      // reset values, index 0x505 is unmapped
      for (i = 0; i < 7; i++)
      begin
         apb(0, adr(IDX_CLK0 + 12'(i)), 32'h0, r, er);
         check(r, i == 4 ? 32'h77 : 32'h0);
         check(er, i == 5);
         check(pready, 32'h1);
      end
      for (i = 0; i < 8; i++)
         run_case(i % 2);
      // alarm per port, pin shows it, read clears
      apb(1, adr(IDX_SYNC), 32'h88, r, er);
      for (i = 0; i < 2; i++)
      begin
         @(posedge mclk_i);
         ev <= 2'(1 << i);
         @(posedge mclk_i);
         ev <= 2'h0;
         repeat (2) @(negedge mclk_i);
         check({pin1, pin0}, 1 << i);
         apb(0, adr(IDX_ALARM), 32'h0, r, er);
         check(r, 1 << i);
         @(negedge mclk_i);
         check({pin1, pin0}, 32'h0);
         apb(0, adr(IDX_ALARM), 32'h0, r, er);
         check(r, 32'h0);
      end
      // free running clock toggles every master cycle at divisor 0
      apb(1, adr(IDX_CLK1), 32'h1, r, er);
      repeat (4) @(negedge mclk_i);
      pv = sc1;
      n = 0;
      repeat (20)
      begin
         @(negedge mclk_i);
         n += (sc1 !== pv);
         pv = sc1;
      end
      check(n, 20);
      end_sim();
   end
endmodule
